// >>> hdl/cisd_core.v
// compact instruction subset core: decode, execute and register port
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "cisd_map.vh"
// Function
// - decode every listed instruction form of the compact subset
// - address formation writes aligned pc plus offset, flags kept
// - literal load reads a word relative to pc into target
// - word, byte, halfword loads at base plus register or immediate
// - signed byte load copies bit 7 into upper bits
// - signed halfword load copies bit 15 into upper bits
// - stores write low 32, 8 or 16 source bits
// - multi load ascending words, writeback unless base is listed
// - multi store ascending words, always writes back final address
// - stack save stores list below active stack pointer
// - stack restore loads list and advances stack pointer
// - special read copies mask, control, status or stack pointer
// - special write sets selected special register, status sets flags
// - mask set instruction sets primary interrupt mask
// - mask clear instruction clears primary interrupt mask
// - bit test ands two registers, updates only N and Z
// - indirect call saves return address then jumps to register
// - half zero extend keeps low 16 bits, clears upper
// - flags not updated keep their previous values
// - Z set for zero result, N set for negative result
// - unaligned load or store is not done, raises hard fault
// - both call forms write link value with bit 0 set
module cisd_core (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  output reg o_mem_req,
  output reg o_mem_write,
  output reg [1:0] o_mem_size,
  output reg [31:0] o_mem_addr,
  output reg [31:0] o_mem_wdata,
  input wire [31:0] i_mem_rdata,
  input wire i_mem_ready,
  input wire i_irq_pending,
  output wire o_irq_accept,
  output reg o_hard_fault,
  output wire o_primary_irq_mask
);
  localparam [2:0] S_HALT = 3'h0;
  localparam [2:0] S_FETCH = 3'h1;
  localparam [2:0] S_FETCH2 = 3'h2;
  localparam [2:0] S_EXEC = 3'h3;
  localparam [2:0] S_MEM = 3'h4;
  localparam [2:0] S_MULTI = 3'h5;
  localparam [2:0] S_FAULT = 3'h6;

  reg [2:0] state_reg;
  reg [31:0] rf_reg [0:12];
  reg [31:0] msp_reg;
  reg [31:0] psp_reg;
  reg [31:0] lr_reg;
  reg [31:0] pc_reg;
  reg [31:0] fault_pc_reg;
  reg [3:0] nzcv_reg;
  reg primary_irq_mask_reg;
  reg spsel_reg;
  reg run_reg;
  reg rd_ack_reg;
  reg [15:0] ir_reg;
  reg [15:0] ir2_reg;
  reg [2:0] ld_rt_reg;
  reg ld_sgn_reg;
  reg [15:0] m_list_reg;
  reg [3:0] m_idx_reg;
  reg m_load_reg;
  reg m_wb_reg;
  reg [3:0] m_wb_idx_reg;
  reg [31:0] m_wb_val_reg;
  integer k;

  function [31:0] rd;
    input [3:0] idx;
    begin
      case (idx)
        4'hd: rd = spsel_reg ? psp_reg : msp_reg;
        4'he: rd = lr_reg;
        4'hf: rd = pc_reg + 32'h4;
        default: rd = rf_reg[idx];
      endcase
    end
  endfunction

  function [31:0] ext_load;
    input [31:0] d;
    input [1:0] sz;
    input sgn;
    begin
      case (sz)
        `CISD_SZ_BYTE: ext_load = {{24{sgn & d[7]}}, d[7:0]};
        `CISD_SZ_HALF: ext_load = {{16{sgn & d[15]}}, d[15:0]};
        default: ext_load = d;
      endcase
    end
  endfunction

  function is_aligned;
    input [31:0] a;
    input [1:0] sz;
    begin
      case (sz)
        `CISD_SZ_HALF: is_aligned = ~a[0];
        `CISD_SZ_WORD: is_aligned = (a[1:0] == 2'h0);
        default: is_aligned = 1'b1;
      endcase
    end
  endfunction

  function [3:0] low_idx;
    input [15:0] l;
    integer i;
    begin
      low_idx = 4'h0;
      for (i = 15; i >= 0; i = i - 1)
        if (l[i])
          low_idx = i[3:0];
    end
  endfunction

  function [31:0] list_bytes;
    input [15:0] l;
    integer i;
    begin
      list_bytes = 32'h0;
      for (i = 0; i < 16; i = i + 1)
        if (l[i])
          list_bytes = list_bytes + 32'h4;
    end
  endfunction

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          be_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // pc as seen by the instruction, word aligned for literal forms
  wire [31:0] pc_al = rd(4'hf) & 32'hffff_fffc;
  wire [31:0] sp_act = rd(4'hd);
  wire is_wide = (ir_reg[15:13] == 3'h7) && (ir_reg[12:11] != 2'h0);
  wire [2:0] ls_op = ir_reg[11:9];
  wire [31:0] imm5 = {27'h0, ir_reg[10:6]};
  wire [31:0] imm8w = {22'h0, ir_reg[7:0], 2'b00};
  wire [31:0] base_lo = rd({1'b0, ir_reg[5:3]});

  // single load/store decode
  reg ls_valid;
  reg ls_load;
  reg ls_sgn;
  reg [1:0] ls_size;
  reg [2:0] ls_rt;
  reg [31:0] ls_addr;
  always @*
  begin
    ls_valid = 1'b1;
    ls_load = ir_reg[11];
    ls_sgn = 1'b0;
    ls_size = `CISD_SZ_WORD;
    ls_rt = ir_reg[2:0];
    ls_addr = base_lo + (imm5 << 2);
    casez (ir_reg[15:11])
      5'b01001:
      begin
        ls_load = 1'b1;
        ls_rt = ir_reg[10:8];
        ls_addr = pc_al + imm8w;
      end
      5'b0101?:
      begin
        ls_addr = base_lo + rd({1'b0, ir_reg[8:6]});
        ls_load = ls_op[2] | (ls_op == 3'h3);
        ls_sgn = (ls_op == 3'h3) | (ls_op == 3'h7);
        case (ls_op)
          3'h1, 3'h5, 3'h7: ls_size = `CISD_SZ_HALF;
          3'h2, 3'h3, 3'h6: ls_size = `CISD_SZ_BYTE;
          default: ls_size = `CISD_SZ_WORD;
        endcase
      end
      5'b0110?: ls_size = `CISD_SZ_WORD;
      5'b0111?:
      begin
        ls_size = `CISD_SZ_BYTE;
        ls_addr = base_lo + imm5;
      end
      5'b1000?:
      begin
        ls_size = `CISD_SZ_HALF;
        ls_addr = base_lo + (imm5 << 1);
      end
      5'b1001?:
      begin
        ls_rt = ir_reg[10:8];
        ls_addr = sp_act + imm8w;
      end
      default: ls_valid = 1'b0;
    endcase
  end

  // multi transfer set-up
  wire is_push = (ir_reg[15:9] == 7'b1011010);
  wire is_pop = (ir_reg[15:9] == 7'b1011110);
  wire [15:0] push_list = {1'b0, ir_reg[8], 6'h0, ir_reg[7:0]};
  wire [15:0] pop_list = {ir_reg[8], 7'h0, ir_reg[7:0]};
  wire [15:0] lm_list = {8'h0, ir_reg[7:0]};
  wire [31:0] lm_base = rd({1'b0, ir_reg[10:8]});
  wire [31:0] ld_val = ext_load(i_mem_rdata, o_mem_size, ld_sgn_reg);
  wire [31:0] tst_res = rd({1'b0, ir_reg[2:0]}) & base_lo;
  wire [31:0] msr_src = rd(ir_reg[3:0]);
  wire [31:0] blx_tgt = rd(ir_reg[6:3]);
  wire bl_s = ir_reg[10];
  wire [31:0] bl_off = {{7{bl_s}}, bl_s, ~(ir2_reg[13] ^ bl_s),
    ~(ir2_reg[11] ^ bl_s), ir_reg[9:0], ir2_reg[10:0], 1'b0};
  wire [7:0] sysm = ir2_reg[7:0];
  wire ctrl_wr = i_avs_write && (i_avs_address == `CISD_OFS_CTRL);
  wire clr_fault = ctrl_wr && i_avs_byteenable[0] &&
    i_avs_writedata[`CISD_CTRL_CLR_FAULT];

  assign o_primary_irq_mask = primary_irq_mask_reg;
  // interrupt requests only pass while the mask is clear
  assign o_irq_accept = i_irq_pending & ~primary_irq_mask_reg;
  assign o_avs_waitrequest = i_avs_read & ~rd_ack_reg;

  task wr;
    input [3:0] idx;
    input [31:0] v;
    begin
      case (idx)
        4'hd:
          if (spsel_reg)
            psp_reg <= {v[31:2], 2'b00};
          else
            msp_reg <= {v[31:2], 2'b00};
        4'he: lr_reg <= v;
        4'hf: pc_reg <= {v[31:1], 1'b0};
        default: rf_reg[idx] <= v;
      endcase
    end
  endtask

  task start_mem;
    input wr_en;
    input [1:0] sz;
    input [31:0] a;
    input [31:0] d;
    begin
      o_mem_req <= 1'b1;
      o_mem_write <= wr_en;
      o_mem_size <= sz;
      o_mem_addr <= a;
      o_mem_wdata <= d;
    end
  endtask

  task go_fault;
    begin
      state_reg <= S_FAULT;
      fault_pc_reg <= pc_reg;
      o_hard_fault <= 1'b1;
    end
  endtask

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= S_HALT;
      for (k = 0; k < 13; k = k + 1)
        rf_reg[k] <= 32'h0;
      msp_reg <= `CISD_RESET_SP;
      psp_reg <= 32'h0;
      lr_reg <= 32'h0;
      pc_reg <= `CISD_RESET_PC;
      fault_pc_reg <= 32'h0;
      nzcv_reg <= 4'h0;
      primary_irq_mask_reg <= 1'b0;
      spsel_reg <= 1'b0;
      run_reg <= `CISD_RESET_RUN;
      ir_reg <= 16'h0;
      ir2_reg <= 16'h0;
      ld_rt_reg <= 3'h0;
      ld_sgn_reg <= 1'b0;
      m_list_reg <= 16'h0;
      m_idx_reg <= 4'h0;
      m_load_reg <= 1'b0;
      m_wb_reg <= 1'b0;
      m_wb_idx_reg <= 4'h0;
      m_wb_val_reg <= 32'h0;
      o_mem_req <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_size <= `CISD_SZ_HALF;
      o_mem_addr <= 32'h0;
      o_mem_wdata <= 32'h0;
      o_hard_fault <= 1'b0;
    end
    else
    begin
      o_hard_fault <= 1'b0;
      if (ctrl_wr && i_avs_byteenable[0])
        run_reg <= i_avs_writedata[`CISD_CTRL_RUN];
      case (state_reg)
        S_HALT:
        begin
          if (i_avs_write && (i_avs_address == `CISD_OFS_PC))
            pc_reg <= be_merge(pc_reg, i_avs_writedata, i_avs_byteenable)
              & 32'hffff_fffe;
          else if (run_reg)
            state_reg <= S_FETCH;
        end
        S_FETCH, S_FETCH2:
        begin
          // only one transfer outstanding keeps program order
          if (!o_mem_req)
          begin
            if (!run_reg && state_reg == S_FETCH)
              state_reg <= S_HALT;
            else
              start_mem(1'b0, `CISD_SZ_HALF, (state_reg == S_FETCH) ?
                pc_reg : pc_reg + 32'h2, 32'h0);
          end
          else if (i_mem_ready)
          begin
            o_mem_req <= 1'b0;
            if (state_reg == S_FETCH2)
            begin
              ir2_reg <= i_mem_rdata[15:0];
              state_reg <= S_EXEC;
            end
            else
            begin
              ir_reg <= i_mem_rdata[15:0];
              if ((i_mem_rdata[15:13] == 3'h7) && (i_mem_rdata[12:11] != 2'h0))
                state_reg <= S_FETCH2;
              else
                state_reg <= S_EXEC;
            end
          end
        end
        S_EXEC:
        begin
          state_reg <= S_FETCH;
          pc_reg <= pc_reg + 32'h2;
          if (ls_valid)
          begin
            if (!is_aligned(ls_addr, ls_size))
              go_fault;
            else
            begin
              // stores drive only the low lanes of the source
              start_mem(~ls_load, ls_size, ls_addr, ext_load(
                rd({1'b0, ls_rt}), ls_size, 1'b0));
              ld_rt_reg <= ls_rt;
              ld_sgn_reg <= ls_sgn;
              state_reg <= S_MEM;
            end
          end
          else if (is_wide)
          begin
            pc_reg <= pc_reg + 32'h4;
            if (ir_reg[15:11] == 5'b11110 && ir2_reg[15:14] == 2'h3 &&
                ir2_reg[12])
            begin
              lr_reg <= (pc_reg + 32'h4) | 32'h1;
              pc_reg <= pc_reg + 32'h4 + bl_off;
            end
            else if (ir_reg == `CISD_OP_SPECIAL_READ_HI &&
                ir2_reg[15:12] == 4'h8)
            begin
              case (sysm)
                8'h00, 8'h01, 8'h02, 8'h03:
                  wr(ir2_reg[11:8], {nzcv_reg, 28'h0});
                `CISD_SYSM_MAIN_SP: wr(ir2_reg[11:8], msp_reg);
                `CISD_SYSM_PROC_SP: wr(ir2_reg[11:8], psp_reg);
                `CISD_SYSM_IRQ_MASK: wr(ir2_reg[11:8], {31'h0, primary_irq_mask_reg});
                `CISD_SYSM_CONTROL:
                  wr(ir2_reg[11:8], {30'h0, spsel_reg, 1'b0});
                default: wr(ir2_reg[11:8], 32'h0);
              endcase
            end
            else if (ir_reg[15:4] == 12'hf38 && ir2_reg[15:8] == 8'h88)
            begin
              case (sysm)
                8'h00, 8'h01, 8'h02, 8'h03: nzcv_reg <= msr_src[31:28];
                `CISD_SYSM_MAIN_SP: msp_reg <= {msr_src[31:2], 2'b00};
                `CISD_SYSM_PROC_SP: psp_reg <= {msr_src[31:2], 2'b00};
                `CISD_SYSM_IRQ_MASK: primary_irq_mask_reg <= msr_src[0];
                `CISD_SYSM_CONTROL: spsel_reg <= msr_src[1];
                default: nzcv_reg <= nzcv_reg;
              endcase
            end
            else
              go_fault;
          end
          else if (ir_reg[15:11] == 5'b10100)
            wr({1'b0, ir_reg[10:8]}, pc_al + imm8w);
          else if (ir_reg[15:12] == 4'hc || is_push || is_pop)
          begin
            m_load_reg <= is_pop | (ir_reg[15:12] == 4'hc & ir_reg[11]);
            if (is_push)
            begin
              m_list_reg <= push_list;
              o_mem_addr <= sp_act - list_bytes(push_list);
              m_wb_val_reg <= sp_act - list_bytes(push_list);
              m_wb_idx_reg <= 4'hd;
              m_wb_reg <= 1'b1;
            end
            else if (is_pop)
            begin
              m_list_reg <= pop_list;
              o_mem_addr <= sp_act;
              m_wb_val_reg <= sp_act + list_bytes(pop_list);
              m_wb_idx_reg <= 4'hd;
              m_wb_reg <= 1'b1;
            end
            else
            begin
              m_list_reg <= lm_list;
              o_mem_addr <= lm_base;
              m_wb_val_reg <= lm_base + list_bytes(lm_list);
              m_wb_idx_reg <= {1'b0, ir_reg[10:8]};
              m_wb_reg <= ~ir_reg[11] | ~lm_list[ir_reg[10:8]];
            end
            if (ir_reg[8:0] == 9'h0 || (ir_reg[15:12] == 4'hc &&
                ir_reg[7:0] == 8'h0))
              go_fault;
            else if ((is_push | is_pop) ? (sp_act[1:0] != 2'h0) :
                (lm_base[1:0] != 2'h0))
              go_fault;
            else
              state_reg <= S_MULTI;
          end
          else if (ir_reg == `CISD_OP_IRQ_MASK_SET)
            primary_irq_mask_reg <= 1'b1;
          else if (ir_reg == `CISD_OP_IRQ_MASK_CLEAR)
            primary_irq_mask_reg <= 1'b0;
          else if (ir_reg[15:6] == 10'h108)
            // carry and overflow untouched by the test
            nzcv_reg <= {tst_res[31], tst_res == 32'h0,
              nzcv_reg[1:0]};
          else if (ir_reg[15:7] == 9'h08f && ir_reg[2:0] == 3'h0)
          begin
            // a target with bit 0 clear would leave the only state
            if (!blx_tgt[0])
              go_fault;
            else
            begin
              lr_reg <= (pc_reg + 32'h2) | 32'h1;
              pc_reg <= {blx_tgt[31:1], 1'b0};
            end
          end
          else if (ir_reg[15:6] == 10'h2ca)
            wr({1'b0, ir_reg[2:0]}, {16'h0, base_lo[15:0]});
          else
            go_fault;
        end
        S_MEM:
          if (i_mem_ready)
          begin
            o_mem_req <= 1'b0;
            if (!o_mem_write)
              wr({1'b0, ld_rt_reg}, ld_val);
            state_reg <= S_FETCH;
          end
        S_MULTI:
          if (!o_mem_req)
          begin
            if (m_list_reg == 16'h0)
            begin
              if (m_wb_reg)
                wr(m_wb_idx_reg, m_wb_val_reg);
              state_reg <= S_FETCH;
            end
            else
            begin
              m_idx_reg <= low_idx(m_list_reg);
              start_mem(~m_load_reg, `CISD_SZ_WORD, o_mem_addr,
                rd(low_idx(m_list_reg)));
            end
          end
          else if (i_mem_ready)
          begin
            o_mem_req <= 1'b0;
            if (m_load_reg)
              wr(m_idx_reg, i_mem_rdata);
            m_list_reg[m_idx_reg] <= 1'b0;
            o_mem_addr <= o_mem_addr + 32'h4;
          end
        S_FAULT:
          if (clr_fault)
            state_reg <= S_HALT;
        default: state_reg <= S_HALT;
      endcase
    end
  end

  // register port: reads answer on the second edge, writes take no wait
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rd_ack_reg <= 1'b0;
      o_avs_readdata <= 32'h0;
    end
    else if (i_avs_read && !rd_ack_reg)
    begin
      rd_ack_reg <= 1'b1;
      case (i_avs_address)
        `CISD_OFS_CTRL: o_avs_readdata <= {31'h0, run_reg};
        `CISD_OFS_STATUS: o_avs_readdata <= {nzcv_reg, 24'h0, spsel_reg,
          primary_irq_mask_reg, state_reg == S_FAULT,
          state_reg != S_HALT && state_reg != S_FAULT};
        `CISD_OFS_PC: o_avs_readdata <= pc_reg;
        `CISD_OFS_FAULT_PC: o_avs_readdata <= fault_pc_reg;
        default: o_avs_readdata <= 32'h0;
      endcase
    end
    else
      rd_ack_reg <= 1'b0;
  end
endmodule // cisd_core

// >>> inc/cisd_map.vh
// constants for the compact instruction subset core
`ifndef CISD_MAP_VH
`define CISD_MAP_VH
`define CISD_OFS_CTRL 4'h0
`define CISD_OFS_STATUS 4'h4
`define CISD_OFS_PC 4'h8
`define CISD_OFS_FAULT_PC 4'hc
`define CISD_CTRL_RUN 0
`define CISD_CTRL_CLR_FAULT 1
`define CISD_STAT_RUNNING 0
`define CISD_STAT_FAULT 1
`define CISD_STAT_IRQ_MASK 2
`define CISD_STAT_SPSEL 3
`define CISD_RESET_PC 32'h0000_0000
`define CISD_RESET_SP 32'h0000_1000
`define CISD_RESET_RUN 1'b0
`define CISD_SZ_BYTE 2'h0
`define CISD_SZ_HALF 2'h1
`define CISD_SZ_WORD 2'h2
`define CISD_SYSM_MAIN_SP 8'h08
`define CISD_SYSM_PROC_SP 8'h09
`define CISD_SYSM_IRQ_MASK 8'h10
`define CISD_SYSM_CONTROL 8'h14
`define CISD_OP_IRQ_MASK_CLEAR 16'hb662
`define CISD_OP_IRQ_MASK_SET 16'hb672
`define CISD_OP_SPECIAL_READ_HI 16'hf3ef
`endif

// >>> verification/cisd_core_sva.sv
// checker of memory bus, fault and mask behaviour at the core ports
`timescale 1ns/1ps
`include "cisd_map.vh"
module cisd_core_sva (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire o_mem_req,
  input wire o_mem_write,
  input wire [1:0] o_mem_size,
  input wire [31:0] o_mem_addr,
  input wire [31:0] o_mem_wdata,
  input wire i_mem_ready,
  input wire i_irq_pending,
  input wire o_irq_accept,
  input wire o_hard_fault,
  input wire o_primary_irq_mask
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  a_req_held: assert property (o_mem_req && !i_mem_ready |=> o_mem_req
    && $stable(o_mem_addr) && $stable(o_mem_size) && $stable(o_mem_write)
    && $stable(o_mem_wdata)) else $error("request changed while waiting");
  a_req_gap: assert property (o_mem_req && i_mem_ready |=> !o_mem_req)
    else $error("no idle cycle after transfer");
  a_half_align: assert property (o_mem_req && o_mem_size == `CISD_SZ_HALF
    |-> !o_mem_addr[0]) else $error("unaligned halfword transfer");
  a_word_align: assert property (o_mem_req && o_mem_size == `CISD_SZ_WORD
    |-> o_mem_addr[1:0] == 2'h0) else $error("unaligned word transfer");
  a_byte_store: assert property (o_mem_req && o_mem_write
    && o_mem_size == `CISD_SZ_BYTE |-> o_mem_wdata[31:8] == 24'h0)
    else $error("byte store upper bits not clear");
  a_half_store: assert property (o_mem_req && o_mem_write
    && o_mem_size == `CISD_SZ_HALF |-> o_mem_wdata[31:16] == 16'h0)
    else $error("half store upper bits not clear");
  a_irq_gate: assert property (o_irq_accept ==
    (i_irq_pending && !o_primary_irq_mask)) else $error("irq gate wrong");
  a_fault_pulse: assert property (o_hard_fault |=> !o_hard_fault)
    else $error("fault pulse longer than one cycle");
  a_fault_quiet: assert property (o_hard_fault |-> !o_mem_req [*4])
    else $error("memory access after fault");
  a_write_nowait: assert property (i_avs_write |-> !o_avs_waitrequest)
    else $error("register write stalled");
  a_read_answer: assert property (i_avs_read && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("register read not answered");
endmodule // cisd_core_sva
bind cisd_core cisd_core_sva i_sva (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_mem_req(o_mem_req),
  .o_mem_write(o_mem_write),
  .o_mem_size(o_mem_size),
  .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata),
  .i_mem_ready(i_mem_ready),
  .i_irq_pending(i_irq_pending),
  .o_irq_accept(o_irq_accept),
  .o_hard_fault(o_hard_fault),
  .o_primary_irq_mask(o_primary_irq_mask)
);

// >>> verification/cisd_mem_model.sv
// behavioural memory and peripheral bus seen by the core
`timescale 1ns/1ps
module cisd_mem_model (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [3:0] i_lat,
  input wire i_req,
  input wire i_write,
  input wire [1:0] i_size,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  output reg [31:0] o_rdata,
  output reg o_ready
);
  reg [31:0] mem [0:1023];
  reg [3:0] cnt_reg;
  reg [31:0] w;
  // data toggles outside a ready cycle so a stale read never passes
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ready <= 1'b0;
      cnt_reg <= 4'h0;
      o_rdata <= 32'h0;
    end
    else if (o_ready)
    begin
      o_ready <= 1'b0;
      cnt_reg <= 4'h0;
      o_rdata <= ~o_rdata;
      if (i_write)
      begin
        w = mem[i_addr[11:2]];
        if (i_size == 2'h0)
          w[{i_addr[1:0], 3'h0} +: 8] = i_wdata[7:0];
        else if (i_size == 2'h1)
          w[{i_addr[1], 4'h0} +: 16] = i_wdata[15:0];
        else
          w = i_wdata;
        mem[i_addr[11:2]] <= w;
      end
    end
    else if (i_req && cnt_reg >= i_lat)
    begin
      w = mem[i_addr[11:2]] >> {i_addr[1:0], 3'h0};
      if (i_size == 2'h0)
        o_rdata <= {24'h0, w[7:0]};
      else if (i_size == 2'h1)
        o_rdata <= {16'h0, w[15:0]};
      else
        o_rdata <= w;
      o_ready <= 1'b1;
    end
    else
    begin
      cnt_reg <= i_req ? cnt_reg + 4'h1 : 4'h0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule // cisd_mem_model

// >>> verification/tb_top.sv
// self-checking bench running small programs on the core
`timescale 1ns/1ps
`include "cisd_map.vh"
module tb_top;
  reg i_ref_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [3:0] i_avs_address = 4'h0;
  reg i_avs_read = 1'b0;
  reg i_avs_write = 1'b0;
  reg [31:0] i_avs_writedata = 32'h0;
  reg i_irq_pending = 1'b1;
  reg [3:0] lat = 4'h0;
  wire [31:0] o_avs_readdata, o_mem_addr, o_mem_wdata, mem_rdata;
  wire o_avs_waitrequest, o_mem_req, o_mem_write, mem_ready;
  wire o_irq_accept, o_hard_fault, o_primary_irq_mask;
  wire [1:0] o_mem_size;
  integer mismatches = 0;
  integer num_checks = 0;
  integer faults = 0;
  integer k;
  reg mask_seen = 1'b0;
  reg [31:0] q;
  reg [15:0] p0 [0:22] = '{16'h480f, 16'h4910, 16'h6008, 16'h7108,
    16'h80c8, 16'h56ca, 16'h5ecc, 16'h88cd, 16'h790e, 16'h4212, 16'hb297,
    16'hc1f4, 16'hb403, 16'hbc08, 16'hf3ef, 16'h8408, 16'hb672, 16'hf3ef,
    16'h8510, 16'hb662, 16'ha601, 16'h4f07, 16'h47b8};
  reg [15:0] p1 [0:8] = '{16'hc178, 16'hb500, 16'hf3ef, 16'h8000,
    16'h6008, 16'hc90c, 16'hc10c, 16'h6009, 16'hde00};
  reg [11:0] ea [0:15] = '{12'h200, 12'h204, 12'h208, 12'h20c, 12'h210,
    12'h214, 12'h218, 12'h21c, 12'h220, 12'h224, 12'h228, 12'h22c,
    12'h230, 12'h234, 12'hff8, 12'hffc};
  reg [31:0] ev [0:15] = '{32'hffff_fff1, 32'hffff_85f1, 32'h0000_85f1,
    32'h0000_00f1, 32'h0000_fff1, 32'h1234_85f1, 32'h0000_0ffc, 32'h1,
    32'h30, 32'h8000_0000, 32'h5a5a_a5a5, 32'h8000_0000, 32'h5a5a_a5a5,
    32'h234, 32'h2f, 32'h214};
  always #20 i_ref_clk = ~i_ref_clk;
  cisd_core i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_mem_req(o_mem_req),
    .o_mem_write(o_mem_write), .o_mem_size(o_mem_size),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(mem_rdata), .i_mem_ready(mem_ready),
    .i_irq_pending(i_irq_pending), .o_irq_accept(o_irq_accept),
    .o_hard_fault(o_hard_fault), .o_primary_irq_mask(o_primary_irq_mask));
  cisd_mem_model i_mem (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_lat(lat),
    .i_req(o_mem_req), .i_write(o_mem_write), .i_size(o_mem_size),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(mem_rdata),
    .o_ready(mem_ready));
  always @(posedge i_ref_clk)
  begin
    if (o_hard_fault === 1'b1)
      faults = faults + 1;
    if (o_primary_irq_mask === 1'b1)
      mask_seen = 1'b1;
  end
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
    end
  endtask
  // holds the request until waitrequest is seen low at an edge, giving up after 20 more edges
  task av(input we, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge i_ref_clk);
      i_avs_read <= ~we;
      i_avs_write <= we;
      i_avs_address <= a;
      i_avs_writedata <= d;
      n = 0;
      @(posedge i_ref_clk);
      while (o_avs_waitrequest !== 1'b0 && n < 20)
      begin
        @(posedge i_ref_clk);
        n = n + 1;
      end
      chk(n < 20, 1'b1, "bus answer");
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
    end
  endtask
  task run(input [31:0] pc);
    integer n;
    begin
      av(1'b1, `CISD_OFS_PC, pc);
      av(1'b1, `CISD_OFS_CTRL, 32'h1);
      n = 0;
      while (o_hard_fault !== 1'b1 && n < 4000)
      begin
        @(posedge i_ref_clk);
        n = n + 1;
      end
      chk(n < 4000, 1'b1, "program end");
      repeat (6) @(posedge i_ref_clk);
    end
  endtask
  task t_regs;
    begin
      av(1'b0, `CISD_OFS_STATUS, 32'h0);
      chk(q, 32'h0, "status after reset");
      av(1'b0, 4'h1, 32'h0);
      chk(q, 32'h0, "unmapped read");
      av(1'b1, `CISD_OFS_STATUS, 32'hffff_ffff);
      av(1'b0, `CISD_OFS_STATUS, 32'h0);
      chk(q, 32'h0, "status read only");
      av(1'b1, `CISD_OFS_PC, 32'h81);
      av(1'b0, `CISD_OFS_PC, 32'h0);
      chk(q, 32'h80, "pc write");
      $display("test registers done");
    end
  endtask
  task t_main;
    begin
      lat <= 4'h0;
      run(32'h0);
      for (k = 0; k < 16; k = k + 1)
        chk(i_mem.mem[ea[k] >> 2], ev[k], "memory word");
      av(1'b0, `CISD_OFS_STATUS, 32'h0);
      chk(q & 32'hf000_0006, 32'h8000_0002, "status flags");
      av(1'b0, `CISD_OFS_FAULT_PC, 32'h0);
      chk(q, 32'h70, "fault pc undefined");
      chk(mask_seen, 1'b1, "mask raised");
      chk(o_irq_accept, 1'b1, "irq accepted");
      chk(faults, 1, "fault count");
      $display("test program done");
    end
  endtask
  task t_unaligned;
    begin
      lat <= 4'h3;
      av(1'b1, `CISD_OFS_CTRL, 32'h2);
      run(32'h80);
      av(1'b0, `CISD_OFS_FAULT_PC, 32'h0);
      chk(q, 32'h80, "fault pc unaligned");
      chk(faults, 2, "fault count");
      $display("test unaligned done");
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    #(40 * 20000);
    mismatches = mismatches + 1;
    $display("BAD %0t watchdog expired", $time);
    wrap_up;
  end
  initial
  begin
    for (k = 0; k < 1024; k = k + 1)
      i_mem.mem[k] = 32'h0;
    for (k = 0; k < 23; k = k + 1)
      i_mem.mem[k >> 1][{k[0], 4'h0} +: 16] = p0[k];
    for (k = 0; k < 9; k = k + 1)
      i_mem.mem[24 + (k >> 1)][{k[0], 4'h0} +: 16] = p1[k];
    i_mem.mem[32] = 32'h0000_58ca;
    i_mem.mem[16] = 32'h1234_85f1;
    i_mem.mem[17] = 32'h200;
    i_mem.mem[18] = 32'h61;
    i_mem.mem[138] = 32'h5a5a_a5a5;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_regs;
    t_main;
    t_unaligned;
    wrap_up;
  end
endmodule // tb_top
